// [rtl/osc_select_regs.svh]
// register offsets, field positions, reset values and fixed factors
// for the oscillator source selector; included by bare name
`ifndef OSC_SELECT_REGS_SVH
`define OSC_SELECT_REGS_SVH

// byte offsets of the APB registers
`define CLOCK_DIVIDER_OFFSET 8'h00
`define PLL_FEEDBACK_OFFSET  8'h04
`define OSCSTAT_OFFSET       8'h08

// clock divider register fields
`define PRE_LSB              0
`define PRE_MSB              4
`define POST_LSB             6
`define POST_MSB             7
`define RCDIV_LSB            8
`define RCDIV_MSB            10

// status register fields
`define STAT_SRC_LSB         0
`define STAT_SRC_MSB         2
`define STAT_PMODE_LSB       4
`define STAT_PMODE_MSB       5
`define STAT_PINFN_BIT       8

// reset values
`define CLOCK_DIVIDER_RESET  11'h000
`define PLL_FEEDBACK_RESET   9'h01E

// fixed factors
`define RC_DIV16_FACTOR      9'h010
`define PRE_FACTOR_BASE      6'h02
`define FB_FACTOR_BASE       10'h002
`define INSTR_DIVIDE         2'h2

`endif

// [rtl/osc_select_pkg.sv]
// types shared by the oscillator source selector
// assumes the constants header is included by the design file
package osc_select_pkg;

  // clock source, one-hot
  typedef enum logic [7:0] {
    src_fast_rc      = 8'h01,
    src_fast_rc_pll  = 8'h02,
    src_primary      = 8'h04,
    src_primary_pll  = 8'h08,
    src_secondary    = 8'h10,
    src_low_power_rc = 8'h20,
    src_rc_div16     = 8'h40,
    src_rc_divn      = 8'h80
  } osc_source_t;

  // primary oscillator mode field
  typedef enum logic [1:0] {
    pmode_ext_clock  = 2'h0,
    pmode_crystal    = 2'h1,
    pmode_hs_crystal = 2'h2,
    pmode_off        = 2'h3
  } primary_mode_t;

endpackage

// [rtl/osc_source_select_pll_divider.sv]
// oscillator source selection, rc post divider, pll rate model and
// instruction clock divider; oscillators arrive as pins, each source
// rate is carried as a one-cycle tick on the single system clock.
// assumes every oscillator input is much slower than clock.
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "osc_select_regs.svh"

// Summary of operation
// [R01] rc clock divided by 2 to 256
// [R02] start source from config fields at reset
// [R03] erased 11/111 starts rc divide-by-n
// [R04] 110 rc/16, 101 low-power rc, 100 secondary
// [R05] 001 rc through pll, 000 plain rc
// [R06] 011 primary via pll, 010 primary direct
// [R07] instruction clock is oscillator clock over two
// [R08] pll prescale 2 to 33 from five bits
// [R09] prescale field zero gives factor two
// [R10] pll multiplies by nine-bit feedback field plus two
// [R11] feedback field 0x1E multiplies by 32
// [R12] postscale 2, 4 or 8; zero gives 2
// [R13] pll rate: input times feedback over both scalers
// [R14] only rc and primary may use pll
// [R15] software keeps vco input 0.8 to 8 MHz
// [R16] software keeps vco output 100 to 200 MHz
// [R17] software keeps result 12.5 to 80 MHz
// [R18] low-power rc also drives watchdog reference
// [R19] config bit sets second pin function
// [R20] reserved source codes fall back to rc
module osc_source_select_pll_divider
(
  input  wire logic        clock,               // 40 MHz system clock
  input  wire logic        resetn,              // synchronous, active low
  input  wire logic [2:0]  initial_source_sel,  // nonvolatile source field
  input  wire logic [1:0]  primary_mode_sel,    // nonvolatile mode field
  input  wire logic        osc_pin_function_cfg,// nonvolatile pin function
  input  wire logic        fast_rc_osc,         // fast rc oscillator level
  input  wire logic        low_power_rc_osc,    // low-power rc level
  input  wire logic        secondary_osc,       // secondary osc level
  input  wire logic        osc_pin_one,         // primary osc pin level
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             osc_clock_tick,      // one pulse per osc edge
  output logic             instruction_clock,   // osc clock over two
  output logic             instruction_tick,    // one pulse per cycle
  output logic             watchdog_ref_tick,   // low-power rc edge
  output logic             osc_pin_two_out,     // second pin drive
  output logic             osc_pin_two_oe       // second pin enable
);

  // decode the source field, reserved codes go to plain rc
  function automatic osc_select_pkg::osc_source_t decode_source
  (
    input logic [2:0] sel
  );
    case (sel)
      3'h7:    decode_source = osc_select_pkg::src_rc_divn;      // R03
      3'h6:    decode_source = osc_select_pkg::src_rc_div16;     // R04
      3'h5:    decode_source = osc_select_pkg::src_low_power_rc; // R04
      3'h4:    decode_source = osc_select_pkg::src_secondary;    // R04
      3'h3:    decode_source = osc_select_pkg::src_primary_pll;  // R06
      3'h2:    decode_source = osc_select_pkg::src_primary;      // R06
      3'h1:    decode_source = osc_select_pkg::src_fast_rc_pll;  // R05
      3'h0:    decode_source = osc_select_pkg::src_fast_rc;      // R05
      default: decode_source = osc_select_pkg::src_fast_rc;      // R20
    endcase
  endfunction

  // encode a source back to its field code for status reads
  function automatic logic [2:0] encode_source
  (
    input osc_select_pkg::osc_source_t src
  );
    case (src)
      osc_select_pkg::src_rc_divn:      encode_source = 3'h7;
      osc_select_pkg::src_rc_div16:     encode_source = 3'h6;
      osc_select_pkg::src_low_power_rc: encode_source = 3'h5;
      osc_select_pkg::src_secondary:    encode_source = 3'h4;
      osc_select_pkg::src_primary_pll:  encode_source = 3'h3;
      osc_select_pkg::src_primary:      encode_source = 3'h2;
      osc_select_pkg::src_fast_rc_pll:  encode_source = 3'h1;
      default:                          encode_source = 3'h0;
    endcase
  endfunction

  // postscale factor from its two-bit field
  function automatic logic [3:0] post_factor
  (
    input logic [1:0] sel
  );
    case (sel)
      2'h0:    post_factor = 4'h2;    // R12
      2'h1:    post_factor = 4'h4;    // R12
      2'h3:    post_factor = 4'h8;    // R12
      default: post_factor = 4'h4;    // reserved code
    endcase
  endfunction

  // synchroniser chains: 0 rc, 1 low-power rc, 2 secondary, 3 primary
  logic [3:0]  sync_a;                 // first stage, read by sync_b only
  logic [3:0]  sync_b;                 // second stage
  logic [3:0]  sync_c;                 // third stage
  logic [3:0]  held;                   // accepted level
  logic [3:0]  next_held;
  logic [3:0]  rise;                   // rising edge, one cycle

  // configuration captured at reset
  osc_select_pkg::osc_source_t   source;
  osc_select_pkg::osc_source_t   next_source;
  osc_select_pkg::primary_mode_t pmode;
  osc_select_pkg::primary_mode_t next_pmode;
  logic        pin_fn;
  logic        next_pin_fn;

  // software registers
  logic [10:0] clock_divider_reg;      // software divider fields
  logic [10:0] next_clock_divider_reg;
  logic [8:0]  pll_feedback_reg;
  logic [8:0]  next_pll_feedback_reg;
  logic [31:0] next_prdata;

  // divider state
  logic [8:0]  rc_cnt;                 // rc post divider count
  logic [8:0]  next_rc_cnt;
  logic [5:0]  pre_cnt;                // pll prescaler count
  logic [5:0]  next_pre_cnt;
  logic [11:0] credit;                 // pll output edges owed
  logic [11:0] next_credit;
  logic        half;                   // instruction clock level
  logic        next_half;
  logic        next_osc_tick;
  logic        next_instr_tick;
  logic        next_wdt_tick;

  // factors and tick paths
  logic [8:0]  rc_factor;
  logic        rc_div_tick;
  logic        pll_in_tick;
  logic [5:0]  prescale_factor;
  logic [9:0]  fb_factor;
  logic [3:0]  postscale_factor;
  logic        pre_tick;
  logic        access;                 // apb access phase
  logic        mapped;

  // three-stage synchronisers on the oscillator pins
  always_ff @(posedge clock)
  begin
    sync_a <= {osc_pin_one, secondary_osc, low_power_rc_osc, fast_rc_osc};
    sync_b <= sync_a;
    sync_c <= sync_b;
  end

  // a change is accepted when stages two and three agree
  always_comb
  begin
    next_held = held;
    for (int i = 0; i < 4; i++)
    begin
      if (sync_b[i] == sync_c[i])
      begin
        next_held[i] = sync_c[i];
      end
    end
    rise = next_held & ~held;
  end

  // factor decode
  always_comb
  begin
    rc_factor = 9'h002 << clock_divider_reg[`RCDIV_MSB:`RCDIV_LSB]; // R01
    if (source == osc_select_pkg::src_rc_div16)
    begin
      rc_factor = `RC_DIV16_FACTOR;                                 // R04
    end
    prescale_factor = `PRE_FACTOR_BASE
      + {1'b0, clock_divider_reg[`PRE_MSB:`PRE_LSB]};               // R08 R09
    fb_factor = `FB_FACTOR_BASE + {1'b0, pll_feedback_reg};     // R10 R11
    postscale_factor =
      post_factor(clock_divider_reg[`POST_MSB:`POST_LSB]);          // R12
    // only rc or primary feeds the pll
    pll_in_tick = (source == osc_select_pkg::src_primary_pll)
                  ? rise[3] : rise[0];                              // R14
  end

  // rate model of rc divider, prescaler, pll and output mux
  always_comb
  begin
    next_rc_cnt = rc_cnt;
    rc_div_tick = 1'b0;
    if (rise[0])
    begin
      if (rc_cnt + 9'h001 >= rc_factor)
      begin
        next_rc_cnt = 9'h000;
        rc_div_tick = 1'b1;                                         // R01
      end
      else
      begin
        next_rc_cnt = rc_cnt + 9'h001;
      end
    end
    next_pre_cnt = pre_cnt;
    pre_tick = 1'b0;
    if (pll_in_tick)
    begin
      if (pre_cnt + 6'h01 >= prescale_factor)
      begin
        next_pre_cnt = 6'h00;
        pre_tick = 1'b1;                                            // R08
      end
      else
      begin
        next_pre_cnt = pre_cnt + 6'h01;
      end
    end
    // owed edges grow by m per prescaled edge, shrink by n2 per output
    next_credit = credit;
    if (pre_tick)
    begin
      next_credit = (credit > 12'hFFF - {2'h0, fb_factor})
                    ? 12'hFFF : credit + {2'h0, fb_factor};          // R13
    end
    // output mux by current source
    case (source)
      osc_select_pkg::src_fast_rc:      next_osc_tick = rise[0];    // R05
      osc_select_pkg::src_rc_divn:      next_osc_tick = rc_div_tick;
      osc_select_pkg::src_rc_div16:     next_osc_tick = rc_div_tick;
      osc_select_pkg::src_low_power_rc: next_osc_tick = rise[1];    // R14
      osc_select_pkg::src_secondary:    next_osc_tick = rise[2];    // R14
      osc_select_pkg::src_primary:      next_osc_tick = rise[3];    // R06
      osc_select_pkg::src_fast_rc_pll,
      osc_select_pkg::src_primary_pll:
      begin
        next_osc_tick = (next_credit >= {8'h00, postscale_factor});
      end
      default:                          next_osc_tick = rise[0];    // R20
    endcase
    if (next_osc_tick && (source == osc_select_pkg::src_fast_rc_pll ||
                          source == osc_select_pkg::src_primary_pll))
    begin
      next_credit = next_credit - {8'h00, postscale_factor};        // R13
    end
    // instruction clock toggles on every oscillator edge
    next_half = next_osc_tick ? ~half : half;                       // R07
    next_instr_tick = next_osc_tick & half;                         // R07
    next_wdt_tick = rise[1];                                        // R18
  end

  // configuration capture and apb register next values
  always_comb
  begin
    next_source = source;
    next_pmode = pmode;
    next_pin_fn = pin_fn;
    next_clock_divider_reg = clock_divider_reg;
    next_pll_feedback_reg = pll_feedback_reg;
    access = psel & penable;
    mapped = (paddr == `CLOCK_DIVIDER_OFFSET) ||
             (paddr == `PLL_FEEDBACK_OFFSET) || (paddr == `OSCSTAT_OFFSET);
    next_prdata = prdata;
    // read data prepared in the setup cycle
    if (psel && !penable && !pwrite)
    begin
      next_prdata = 32'h0000_0000;
      case (paddr)
        `CLOCK_DIVIDER_OFFSET: next_prdata[10:0] = clock_divider_reg;
        `PLL_FEEDBACK_OFFSET: next_prdata[8:0] = pll_feedback_reg;
        `OSCSTAT_OFFSET:
        begin
          next_prdata[`STAT_SRC_MSB:`STAT_SRC_LSB] = encode_source(source);
          next_prdata[`STAT_PMODE_MSB:`STAT_PMODE_LSB] = pmode;
          next_prdata[`STAT_PINFN_BIT] = pin_fn;
        end
        default: next_prdata = 32'h0000_0000;
      endcase
    end
    // writes take effect in the access cycle
    if (access && pwrite)
    begin
      if (paddr == `CLOCK_DIVIDER_OFFSET)
      begin
        next_clock_divider_reg = {pwdata[`RCDIV_MSB:`RCDIV_LSB],
                                  pwdata[`POST_MSB:`POST_LSB], 1'b0,
                                  pwdata[`PRE_MSB:`PRE_LSB]};
      end
      if (paddr == `PLL_FEEDBACK_OFFSET)
      begin
        next_pll_feedback_reg = pwdata[8:0];
      end
    end
    // configuration fields sampled while reset is held
    if (!resetn)
    begin
      next_source = decode_source(initial_source_sel);          // R02 R03
      next_pmode = osc_select_pkg::primary_mode_t'(primary_mode_sel); // R02
      next_pin_fn = osc_pin_function_cfg;                           // R19
      next_clock_divider_reg = `CLOCK_DIVIDER_RESET;
      next_pll_feedback_reg = `PLL_FEEDBACK_RESET;
      next_prdata = 32'h0000_0000;
    end
  end

  // state registers
  always_ff @(posedge clock)
  begin
    source <= next_source;
    pmode <= next_pmode;
    pin_fn <= next_pin_fn;
    clock_divider_reg <= next_clock_divider_reg;
    pll_feedback_reg <= next_pll_feedback_reg;
    prdata <= next_prdata;
    if (!resetn)
    begin
      held <= 4'h0;
      rc_cnt <= 9'h000;
      pre_cnt <= 6'h00;
      credit <= 12'h000;
      half <= 1'b0;
      osc_clock_tick <= 1'b0;
      instruction_tick <= 1'b0;
      watchdog_ref_tick <= 1'b0;
    end
    else
    begin
      held <= next_held;
      rc_cnt <= next_rc_cnt;
      pre_cnt <= next_pre_cnt;
      credit <= next_credit;
      half <= next_half;
      osc_clock_tick <= next_osc_tick;
      instruction_tick <= next_instr_tick;
      watchdog_ref_tick <= next_wdt_tick;
    end
  end

  // apb handshake, zero wait states
  always_comb
  begin
    pready = 1'b1;
    pslverr = access & ~mapped;
    instruction_clock = half;
    // second pin: released while a primary source is selected in any mode but external clock
    osc_pin_two_oe = ~(source == osc_select_pkg::src_primary ||
                       source == osc_select_pkg::src_primary_pll) ||
                     (pmode == osc_select_pkg::pmode_ext_clock);    // R19
    osc_pin_two_out = pin_fn ? 1'b0 : half;                         // R19
    if (pin_fn)
    begin
      osc_pin_two_oe = 1'b0;                                        // R19
    end
  end

endmodule

// [verification/osc_select_assertions.sv]
// port checker for the oscillator source selector
// assumes config fields are held steady from reset onwards
`timescale 1ns/1ps
module osc_select_assertions
(
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic [2:0]  initial_source_sel,
  input wire logic        osc_pin_function_cfg,
  input wire logic        fast_rc_osc,
  input wire logic        low_power_rc_osc,
  input wire logic        secondary_osc,
  input wire logic        osc_pin_one,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        osc_clock_tick,
  input wire logic        instruction_clock,
  input wire logic        watchdog_ref_tick,
  input wire logic        osc_pin_two_out,
  input wire logic        osc_pin_two_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  logic [2:0] sel;    // source field in force
  logic       mapped; // access hits one of three words
  logic       access; // apb access phase
  assign sel    = initial_source_sel;
  assign mapped = paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08;
  assign access = psel && penable;

  // accepted pin edge reaches the tick within the sync delay
  sequence osc_soon;
    ##[3:5] osc_clock_tick;
  endsequence
  sequence wdt_soon;
    ##[3:5] watchdog_ref_tick;
  endsequence

  plain_rc_a: assert property (sel == 3'h0 && $rose(fast_rc_osc) |->
    osc_soon) else $error("plain rc edge gave no tick");
  low_rc_src_a: assert property (sel == 3'h5 && $rose(low_power_rc_osc)
    |-> osc_soon) else $error("low-power rc edge gave no tick");
  sec_src_a: assert property (sel == 3'h4 && $rose(secondary_osc)
    |-> osc_soon) else $error("secondary edge gave no tick");
  prim_src_a: assert property (sel == 3'h2 && $rose(osc_pin_one)
    |-> osc_soon) else $error("primary edge gave no tick");
  wdt_ref_a: assert property ($rose(low_power_rc_osc) |-> wdt_soon)
    else $error("watchdog reference tick missing");
  bypass_single_a: assert property (sel != 3'h1 && sel != 3'h3 &&
    osc_clock_tick |=> !osc_clock_tick)
    else $error("non pll source gave a double tick");
  icl_toggle_a: assert property (osc_clock_tick |->
    ##[0:1] $changed(instruction_clock))
    else $error("instruction clock did not toggle");
  icl_hold_a: assert property (!osc_clock_tick &&
    !$past(osc_clock_tick) |-> $stable(instruction_clock))
    else $error("instruction clock moved without tick");
  pin_gpio_a: assert property (osc_pin_function_cfg |->
    !osc_pin_two_oe) else $error("pin two driven in io mode");
  pin_clk_a: assert property (osc_pin_two_oe && !osc_pin_function_cfg
    |-> osc_pin_two_out == instruction_clock)
    else $error("pin two not carrying instruction clock");
  bad_addr_a: assert property (access && !mapped |-> pslverr)
    else $error("unmapped access without error");
  good_addr_a: assert property (access && mapped |-> !pslverr)
    else $error("mapped access flagged error");
  bad_read_a: assert property (access && !mapped && !pwrite |->
    prdata == 32'h0) else $error("unmapped read not zero");
endmodule

bind osc_source_select_pll_divider osc_select_assertions
  i_osc_select_assertions (.clock, .resetn, .initial_source_sel,
  .osc_pin_function_cfg, .fast_rc_osc, .low_power_rc_osc,
  .secondary_osc, .osc_pin_one, .psel, .penable, .pwrite, .paddr,
  .prdata, .pslverr, .osc_clock_tick, .instruction_clock,
  .watchdog_ref_tick, .osc_pin_two_out, .osc_pin_two_oe);

// [verification/tb.sv]
// self-checking bench: apb register access and tick counting
// assumes the design answers apb in the first access cycle
`timescale 1ns/1ps
`include "osc_select_regs.svh"
`define CHK(a, e, m) n_compared++; if ((a) !== (e)) begin n_errors++; $display("CHECK FAILED %0t %s", $time, m); end
module tb;
  logic        clock   = 1'b0;     // system clock
  logic        resetn  = 1'b0;     // reset, active low
  logic        psel    = 1'b0;     // apb select
  logic        penable = 1'b0;     // apb enable
  logic        pwrite  = 1'b0;     // apb direction
  logic [7:0]  paddr   = 8'h00;    // apb address
  logic [31:0] pwdata  = 32'h0;    // apb write data
  logic [2:0]  src     = 3'h7;     // source config field
  logic [1:0]  pmode   = 2'h3;     // primary mode config field
  logic        fn      = 1'b0;     // pin two function bit
  logic [3:0]  osc     = 4'h0;     // rc, low-power rc, secondary, pin one
  logic [31:0] prdata;             // read data
  logic [31:0] rd;                 // last read word
  logic        pready, pslverr, err, otick, icl, itick, wtick, p2o, p2e;
  int          n_errors, n_compared, n_osc, n_ins, n_wdt, cyc;

  osc_source_select_pll_divider i_osc_source_select_pll_divider
  (
    .clock(clock), .resetn(resetn), .initial_source_sel(src),
    .primary_mode_sel(pmode), .osc_pin_function_cfg(fn),
    .fast_rc_osc(osc[0]), .low_power_rc_osc(osc[1]),
    .secondary_osc(osc[2]), .osc_pin_one(osc[3]), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_clock_tick(otick), .instruction_clock(icl),
    .instruction_tick(itick), .watchdog_ref_tick(wtick),
    .osc_pin_two_out(p2o), .osc_pin_two_oe(p2e)
  );

  // half period of 12.5 ns gives 40 MHz
  always #12.5 clock = ~clock;

  // tick counters and the hang guard
  always @(posedge clock)
  begin
    cyc++;
    if (otick === 1'b1) n_osc++;
    if (itick === 1'b1) n_ins++;
    if (wtick === 1'b1) n_wdt++;
    if (cyc == 20000)
    begin
      n_errors++;
      final_report();
    end
  end

  // prints counts and verdict, ends the run
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // one apb transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // config fields latch while reset is low
  task automatic restart(input logic [2:0] s, input logic [1:0] m,
                         input logic f);
    @(posedge clock);
    src <= s; pmode <= m; fn <= f; resetn <= 1'b0;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
  endtask

  // reset into a source, program dividers, count ticks for n edges
  task automatic scen(input logic [2:0] s, input logic [1:0] m,
    input logic f, input logic [31:0] cdiv, input logic [31:0] fbd,
    input int idx, input int n, input int exp);
    restart(s, m, f);
    apb(1'b0, `CLOCK_DIVIDER_OFFSET, 32'h0);
    `CHK(rd, 32'h0, "clock divider reset")
    apb(1'b0, `PLL_FEEDBACK_OFFSET, 32'h0);
    `CHK(rd, 32'h1E, "feedback reset")
    apb(1'b0, `OSCSTAT_OFFSET, 32'h0);
    `CHK(rd, {23'h0, f, 2'h0, m, 1'b0, s}, "status word")
    `CHK(p2e, ~(f | (s[2:1] == 2'h1 & (m == 2'h1 | m == 2'h2))),
      "pin oe")
    apb(1'b1, `CLOCK_DIVIDER_OFFSET, cdiv);
    apb(1'b1, `PLL_FEEDBACK_OFFSET, fbd);
    apb(1'b0, `CLOCK_DIVIDER_OFFSET, 32'h0);
    `CHK(rd, cdiv, "clock divider readback")
    n_osc = 0; n_ins = 0; n_wdt = 0;
    repeat (n)
    begin
      repeat (4) @(posedge clock);
      osc[idx] <= 1'b1;
      repeat (4) @(posedge clock);
      osc[idx] <= 1'b0;
    end
    repeat (60) @(posedge clock);
    `CHK(n_osc, exp, "oscillator ticks")
    `CHK(n_ins, exp / 2, "instruction ticks")
    `CHK(n_wdt, (idx == 1) ? n : 0, "watchdog ticks")
  endtask

  // main sequence: every source code, then register refusals
  initial
  begin
    scen(3'h7, 2'h3, 1'b0, 32'h000, 32'h1E, 0, 8, 4);
    scen(3'h7, 2'h3, 1'b0, 32'h700, 32'h1E, 0, 512, 2);
    scen(3'h6, 2'h3, 1'b1, 32'h000, 32'h1E, 0, 32, 2);
    scen(3'h5, 2'h3, 1'b0, 32'h042, 32'h0E, 1, 6, 6);
    scen(3'h4, 2'h3, 1'b0, 32'h042, 32'h1E, 2, 6, 6);
    scen(3'h1, 2'h3, 1'b0, 32'h000, 32'h1E, 0, 6, 48);
    scen(3'h0, 2'h3, 1'b1, 32'h042, 32'h1E, 0, 6, 6);
    scen(3'h3, 2'h2, 1'b0, 32'h042, 32'h1E, 3, 8, 16);
    scen(3'h3, 2'h1, 1'b0, 32'h01F, 32'h40, 3, 33, 33);
    scen(3'h3, 2'h0, 1'b0, 32'h0C0, 32'h0E, 3, 6, 6);
    scen(3'h2, 2'h0, 1'b0, 32'h000, 32'h1E, 3, 6, 6);
    restart(3'h7, 2'h3, 1'b0);
    apb(1'b1, 8'h0C, 32'hFFFFFFFF);
    `CHK(err, 1'b1, "unmapped write error")
    apb(1'b0, 8'h0C, 32'h0);
    `CHK(err, 1'b1, "unmapped read error")
    `CHK(rd, 32'h0, "unmapped read data")
    apb(1'b1, `OSCSTAT_OFFSET, 32'hFFFFFFFF);
    `CHK(err, 1'b0, "status write error")
    apb(1'b0, `OSCSTAT_OFFSET, 32'h0);
    `CHK(rd, 32'h37, "status unchanged")
    apb(1'b0, `CLOCK_DIVIDER_OFFSET, 32'h0);
    `CHK(rd, 32'h0, "divider untouched")
    final_report();
  end
endmodule
